// ### hss_ctrl.sv
/*
 * Control of a dual high side switch: two PWM modulators, external
 * clock monitor, internal clock calibration, fault delatching, fault
 * flags and channel mirroring for parallel operation.
 * Assumes all inputs synchronous to clk; register contents arrive as
 * plain ports, reads and writes as one-cycle strobes.
 */
`timescale 1ns/1ps
`include "hss_pwm_defs.svh"

////////////////////////////////////////////////////////////////////////
// Behaviour
// - latched channel turns on again only after delatch; fault pin high only when none latched
// - delatch by fault control 1-0-1 or retry reset, effective at turn-on edge
// - fault control = (direct input and direct not disabled) or on bit
// - delatch sequence during retry turns channel on unconditionally
// - power-on delatches all channels and clears all fault flags
// - fail-safe entry in fault mode delatches and resets registers
// - new faults in fail-safe neither reset retry nor delatch
// - independent modulator per channel; clock select picks internal or external
// - on bit clear is off; duty n gives (n+1)/256; all ones full on
// - divide by 256, or 512 with prescaler on external clock
// - switch-on delay of code times 32 PWM clock periods
// - enabling both together on external clock synchronises channels
// - bad external clock is ignored, fault pin low, clock-fail set
// - clock-fail clears only after read and clock back in range, or at power-on
// - calibration measures chip select low pulse, sets internal period
// - pulse outside window leaves the internal period unchanged
// - parallel mode mirrors channel 0 settings except channel 1 diagnostics
// - channel 0 flags copy to channel 1 on new events; 3-5 independent
// - latched fault flag survives reads until delatched
module hss_ctrl #(
   parameter int PER_W = 12
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rstn,
   input  wire logic                          ce,
   // configuration
   input  wire hss_pwm_pkg::chan_cfg_t [1:0]  cfg,
   input  wire logic                          parallel,
   // pins
   input  wire logic                          ext_clk,
   input  wire logic                          chip_select_n,
   // events and strobes
   input  wire logic                          cal_cmd,
   input  wire logic                          diag_read,
   input  wire logic [1:0]                    flags_read,
   input  wire hss_pwm_pkg::chan_evt_t [1:0]  evt,
   input  wire hss_pwm_pkg::fault_flags_t [1:0] fault_evt,
   input  wire hss_pwm_pkg::fault_flags_t [1:0] fault_cause,
   input  wire logic                          fault_now,
   input  wire logic                          por,
   input  wire logic                          failsafe,
   input  wire logic                          fault_mode,
   // outputs
   output logic [1:0]                         out_on,
   output logic                               fault_status_out_n,
   output logic                               clock_fail,
   output logic [1:0]                         latched,
   output logic [1:0]                         uncond_on,
   output logic                               regs_reset,
   output hss_pwm_pkg::fault_flags_t [1:0]    fault_flags_reg,
   output hss_pwm_pkg::chan_cfg_t             eff_cfg1,
   output logic [PER_W-1:0]                   int_period
);

   localparam logic [PER_W-1:0] CSB_MIN = PER_W'(`CSB_MIN_CYC);
   localparam logic [PER_W-1:0] CSB_MAX = PER_W'(`CSB_MAX_CYC);
   localparam logic [PER_W-1:0] EXT_MIN = PER_W'(`EXT_MIN_CYC);
   localparam logic [PER_W-1:0] EXT_MAX = PER_W'(`EXT_MAX_CYC);
   localparam logic [PER_W-1:0] INT_DEF = PER_W'(`INT_PER_DEF_CYC);
   localparam logic [PER_W-1:0] SAT     = {PER_W{1'b1}};

   /////////////////////////////////////////////////////////////////////
   // parallel mirroring

   hss_pwm_pkg::chan_cfg_t eff [2];
   wire hss_pwm_pkg::chan_cfg_t mirror =
      hss_pwm_pkg::chan_cfg_t'({cfg[0][$bits(cfg[0])-1:3], cfg[1].diag_cfg});
   assign eff[0] = cfg[0];
   assign eff[1] = parallel ? mirror : cfg[1];

   /////////////////////////////////////////////////////////////////////
   // external clock monitor

   logic             ext_q;
   logic [PER_W-1:0] ext_cnt;
   logic             fail_read;
   wire ext_rise  = ext_clk && !ext_q;
   wire mon_on    = (eff[0].pwm_en && !eff[0].clk_int) ||
                    (eff[1].pwm_en && !eff[1].clk_int);
   wire too_slow  = ext_cnt > EXT_MAX;
   wire too_fast  = ext_rise && ext_cnt < EXT_MIN;
   wire ext_bad   = mon_on && (too_slow || too_fast);
   wire ext_good  = ext_rise && !too_fast && !too_slow;
   wire fail_clr  = clock_fail && fail_read && ext_good && !ext_bad;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ext_q      <= 1'b0;
         ext_cnt    <= '0;
         clock_fail <= 1'b0;
         fail_read  <= 1'b0;
      end else if (ce) begin
         ext_q   <= ext_clk;
         ext_cnt <= ext_rise ? PER_W'(1) : (ext_cnt == SAT ? SAT : ext_cnt + PER_W'(1));
         if (por) begin
            clock_fail <= 1'b0;
            fail_read  <= 1'b0;
         end else if (ext_bad) begin
            clock_fail <= 1'b1; // set wins over the read
         end else if (fail_clr) begin
            clock_fail <= 1'b0;
            fail_read  <= 1'b0;
         end else if (diag_read && clock_fail) begin
            fail_read  <= 1'b1;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////
   // internal clock and calibration

   hss_pwm_pkg::cal_state_t cal_st;
   logic             csn_q;
   logic [PER_W-1:0] csb_cnt;
   logic [PER_W-1:0] int_cnt;
   wire csn_fall = !chip_select_n && csn_q;
   wire csn_rise = chip_select_n && !csn_q;
   wire cal_done = cal_st == hss_pwm_pkg::CAL_MEASURE && csn_rise;
   wire cal_ok   = csb_cnt >= CSB_MIN && csb_cnt <= CSB_MAX;
   wire int_tick = int_cnt >= int_period - PER_W'(1);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cal_st     <= hss_pwm_pkg::CAL_IDLE;
         csn_q      <= 1'b1;
         csb_cnt    <= '0;
         int_cnt    <= '0;
         int_period <= INT_DEF;
      end else if (ce) begin
         csn_q   <= chip_select_n;
         int_cnt <= int_tick ? '0 : int_cnt + PER_W'(1);
         if (cal_st == hss_pwm_pkg::CAL_MEASURE && csb_cnt != SAT) begin
            csb_cnt <= csb_cnt + PER_W'(1);
         end
         unique case (cal_st)
            hss_pwm_pkg::CAL_IDLE: begin
               if (cal_cmd) begin
                  cal_st <= hss_pwm_pkg::CAL_ARMED;
               end
            end
            hss_pwm_pkg::CAL_ARMED: begin
               if (csn_fall) begin
                  cal_st  <= hss_pwm_pkg::CAL_MEASURE;
                  csb_cnt <= PER_W'(1);
               end
            end
            hss_pwm_pkg::CAL_MEASURE: begin
               if (csn_rise) begin
                  cal_st <= hss_pwm_pkg::CAL_IDLE;
               end
            end
            default: cal_st <= hss_pwm_pkg::CAL_IDLE;
         endcase
         if (cal_done && cal_ok) begin
            int_period <= csb_cnt; // period per step, times 256 per cycle
         end
      end
   end

   /////////////////////////////////////////////////////////////////////
   // modulators and per-channel delatch

   logic fs_q;
   wire fs_entry  = failsafe && !fs_q && fault_mode;
   wire glob_clr  = por || fs_entry;

   for (genvar x = 0; x < 2; x++) begin : g_ch
      logic fc_q;
      logic seen_low;
      logic pend;
      hss_pwm_pkg::fault_flags_t keep_mask;
      hss_pwm_pkg::fault_flags_t set_vec;
      wire fc      = (evt[x].in_pin && !eff[x].dir_dis) || eff[x].on;
      wire fc_rise = fc && !fc_q;
      wire fc_fall = !fc && fc_q;
      wire seq_ok  = fc_rise && seen_low && !evt[x].cause; // 1-0-1
      wire turn_on = fc_rise || evt[x].retry_turn_on;
      // in fail-safe the sequence or a pending retry reset still delatches
      wire delatch = latched[x] && !evt[x].cause &&
                     (seq_ok || (pend && turn_on));
      wire force_on = !latched[x] && evt[x].retry_busy && seq_ok;

      // latched fault bits survive reads
      assign keep_mask = fault_cause[x] | (latched[x] ? 6'b00_0111 : 6'b00_0000);
      // parallel: channel 0 events reach channel 1, 3 to 5 stay own
      if (x == 1) begin : g_par
         assign set_vec = fault_evt[1] |
                          (parallel ? (fault_evt[0] & 6'b00_0111) : 6'b00_0000);
      end else begin : g_solo
         assign set_vec = fault_evt[0];
      end

      hss_pwm_mod u_mod (
         .clk      (clk),
         .rstn     (rstn),
         .ce       (ce),
         .cfg      (eff[x]),
         .int_tick (int_tick),
         .ext_tick (ext_rise),
         .clk_fail (clock_fail),
         .out_on   (out_on[x])
      );

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            fc_q               <= 1'b0;
            seen_low           <= 1'b0;
            pend               <= 1'b0;
            latched[x]         <= 1'b0;
            uncond_on[x]       <= 1'b0;
            fault_flags_reg[x] <= '0;
         end else if (ce) begin
            fc_q         <= fc;
            uncond_on[x] <= force_on;
            if (fc_fall && (latched[x] || evt[x].retry_busy)) begin
               seen_low <= 1'b1;
            end else if (fc_rise) begin
               seen_low <= 1'b0;
            end
            if (glob_clr) begin
               latched[x] <= 1'b0;
               pend       <= 1'b0;
            end else if (evt[x].latch_evt) begin
               latched[x] <= 1'b1; // new latch wins over delatch
            end else if (delatch) begin
               latched[x] <= 1'b0;
               pend       <= 1'b0;
            end else if (evt[x].retry_reset && evt[x].retry_en && latched[x]) begin
               pend <= 1'b1; // waits for the turn-on edge
            end
            if (por) begin
               fault_flags_reg[x] <= '0;
            end else if (flags_read[x]) begin
               fault_flags_reg[x] <= (fault_flags_reg[x] & keep_mask) | set_vec;
            end else begin
               fault_flags_reg[x] <= fault_flags_reg[x] | set_vec;
            end
         end
      end
   end

   /////////////////////////////////////////////////////////////////////
   // global outputs

   wire next_fsb_n = !(|latched || clock_fail || fault_now);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fs_q               <= 1'b0;
         regs_reset         <= 1'b0;
         fault_status_out_n <= 1'b1;
         eff_cfg1           <= '0;
      end else if (ce) begin
         fs_q               <= failsafe;
         regs_reset         <= fs_entry; // except power-on and parallel bits
         fault_status_out_n <= next_fsb_n;
         eff_cfg1           <= eff[1];
      end
   end

   AST_FSB_LATCH: assert property (@(posedge clk) disable iff (!rstn)
      ce && |latched |=> !fault_status_out_n) else $error("fault pin high while latched");

   AST_POR_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
      ce && por |=> latched == 2'b00 && fault_flags_reg == '0)
      else $error("power-on left latch or flags");

   AST_FS_ENTRY: assert property (@(posedge clk) disable iff (!rstn)
      ce && failsafe && !fs_q && fault_mode && !(|{evt[1].latch_evt, evt[0].latch_evt})
      |=> latched == 2'b00 && regs_reset) else $error("fail-safe entry kept latch");

   AST_FS_NO_DELATCH: assert property (@(posedge clk) disable iff (!rstn)
      ce && fs_q && failsafe && !por && latched[0] && !g_ch[0].seq_ok && !g_ch[0].pend
      |=> latched[0]) else $error("delatch in fail-safe without sequence");

   AST_CLKFAIL_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      ce && clock_fail && !fail_read && !por |=> clock_fail)
      else $error("clock-fail cleared before read");

   AST_CLKFAIL_FSB: assert property (@(posedge clk) disable iff (!rstn)
      ce && ext_bad ##1 ce |=> clock_fail && !fault_status_out_n)
      else $error("bad clock not flagged");

   AST_CAL_REJECT: assert property (@(posedge clk) disable iff (!rstn)
      ce && cal_done && !cal_ok |=> $stable(int_period))
      else $error("out-of-window calibration taken");

   AST_CAL_TAKE: assert property (@(posedge clk) disable iff (!rstn)
      ce && cal_done && cal_ok |=> int_period == $past(csb_cnt))
      else $error("calibration not applied");

   AST_PAR_MIRROR: assert property (@(posedge clk) disable iff (!rstn)
      ce && parallel |=> eff_cfg1.duty == $past(cfg[0].duty) &&
      eff_cfg1.diag_cfg == $past(cfg[1].diag_cfg)) else $error("mirror wrong");

   AST_LATCH_FLAG: assert property (@(posedge clk) disable iff (!rstn)
      ce && latched[0] && fault_flags_reg[0][`FLT_OC] && !por |=> fault_flags_reg[0][`FLT_OC])
      else $error("latched flag cleared");

endmodule // hss_ctrl

// ### hss_pwm_defs.svh
/*
 * Constants of the switch-channel control block: fault flag positions,
 * timing figures and derived clock counts.
 * Assumes a 20 MHz system clock; included by its bare name.
 */
`ifndef HSS_PWM_DEFS_SVH
`define HSS_PWM_DEFS_SVH

`define CLK_PERIOD_NS   50
// fault flag bit positions
`define FLT_OC          0
`define FLT_SC          1
`define FLT_OT          2
`define FLT_ON_OPEN_LOAD_FLAG        3
`define FLT_OFF_OPEN_LOAD_FLAG       4
`define FLT_OS          5
// switch-on delay step, in PWM clock periods
`define DELAY_STEP      32
`define DUTY_FULL       8'hFF
// calibration pulse window on the chip select
`define CSB_MIN_NS      20000
`define CSB_MAX_NS      150000
`define CSB_MIN_CYC     ((`CSB_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CSB_MAX_CYC     (`CSB_MAX_NS / `CLK_PERIOD_NS)
// allowed external clock period window
`define EXT_PER_MIN_NS  10000
`define EXT_PER_MAX_NS  100000
`define EXT_MIN_CYC     ((`EXT_PER_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_MAX_CYC     (`EXT_PER_MAX_NS / `CLK_PERIOD_NS)
// default internal PWM clock period
`define INT_PER_DEF_NS  19500
`define INT_PER_DEF_CYC (`INT_PER_DEF_NS / `CLK_PERIOD_NS)

`endif

// ### hss_pwm_pkg.sv
/*
 * Types shared by the channel modulator and the control top.
 * Assumes the constants header is included where numbers are needed.
 */
package hss_pwm_pkg;

   // per-channel settings; diag_cfg stays last (low bits)
   typedef struct packed {
      logic [7:0] duty;
      logic       on;
      logic       pwm_en;
      logic       clk_int;
      logic       prescale;
      logic [2:0] delay;
      logic       dir_dis;
      logic [2:0] diag_cfg;
   } chan_cfg_t;

   // per-channel status from protection and retry logic
   typedef struct packed {
      logic       in_pin;
      logic       latch_evt;
      logic       cause;
      logic       retry_reset;
      logic       retry_en;
      logic       retry_busy;
      logic       retry_turn_on;
   } chan_evt_t;

   typedef logic [5:0] fault_flags_t;

   typedef enum logic [1:0] {
      CAL_IDLE    = 2'b00,
      CAL_ARMED   = 2'b01,
      CAL_MEASURE = 2'b11
   } cal_state_t;

endpackage

// ### hss_pwm_mod.sv
/*
 * One channel PWM modulator with prescaler and switch-on delay.
 * Assumes clock ticks arrive as one-cycle pulses on clk.
 */
`timescale 1ns/1ps
`include "hss_pwm_defs.svh"

module hss_pwm_mod (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic                   ce,
   // settings and clocks
   input  wire hss_pwm_pkg::chan_cfg_t cfg,
   input  wire logic                   int_tick,
   input  wire logic                   ext_tick,
   input  wire logic                   clk_fail,
   // output state
   output logic                        out_on
);

   logic       half;
   logic       en_q;
   logic [7:0] cnt;
   logic [7:0] dly;

   wire ignore   = clk_fail && !cfg.clk_int;
   wire ext_sel  = ext_tick && (!cfg.prescale || half);
   wire tick     = cfg.clk_int ? int_tick : ext_sel;
   wire en_rise  = cfg.pwm_en && !en_q;
   wire running  = cfg.pwm_en && !ignore && dly == 8'h00;
   wire cmp_on   = cfg.duty == `DUTY_FULL || cnt <= cfg.duty;
   wire [7:0] dly_load = 8'({cfg.delay, 5'b0_0000}); // code * 32

   // off without on bit; plain on bit when not modulating or clock ignored
   wire next_out = !cfg.on ? 1'b0 :
                   (!cfg.pwm_en || ignore) ? 1'b1 :
                   running && cmp_on;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         half   <= 1'b0;
         en_q   <= 1'b0;
         cnt    <= 8'h00;
         dly    <= 8'h00;
         out_on <= 1'b0;
      end else if (ce) begin
         en_q   <= cfg.pwm_en;
         out_on <= next_out;
         if (ext_tick) begin
            half <= !half;
         end
         if (!cfg.pwm_en) begin
            cnt <= 8'h00;
            dly <= 8'h00;
            half <= 1'b0;
         end else if (en_rise) begin
            // enable edge restarts this channel's counter and loads its delay
            cnt <= 8'h00;
            dly <= dly_load;
         end else if (tick && !ignore) begin
            if (dly != 8'h00) begin
               dly <= dly - 8'h01;
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   end

   AST_OFF_WHEN_NO_ON: assert property (@(posedge clk) disable iff (!rstn)
      ce && !cfg.on |=> !out_on) else $error("channel on while on bit clear");

   AST_FULL_ON: assert property (@(posedge clk) disable iff (!rstn)
      ce && cfg.on && running && cfg.duty == 8'hFF |=> out_on)
      else $error("full duty not fully on");

endmodule // hss_pwm_mod

// ### ext_clk_src.sv
/*
 * Host-side external PWM clock source for the switch-channel bench.
 * Assumes the bench clock; the period is counted in clk cycles.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module ext_clk_src (
   // clock
   input  wire logic        clk,
   // control
   input  wire logic        run,
   input  wire logic [11:0] period,
   // clock pin
   output logic             ext_clk
);
   logic [11:0] cnt;

   // pin stands low between runs so no stray edge reaches the monitor
   always @(posedge clk) begin
      if (!run) begin
         cnt     <= 12'h000;
         ext_clk <= 1'h0;
      end else begin
         cnt     <= (cnt >= period - 12'h001) ? 12'h000 : cnt + 12'h001;
         ext_clk <= (cnt < (period >> 1));
      end
   end
endmodule // ext_clk_src

// ### testbench.sv
/*
 * Self-checking bench of the switch-channel control block.
 * Assumes hss_ctrl, its package and the ext_clk_src host model.
 */
`timescale 1ns/1ps
`include "hss_pwm_defs.svh"
////////////////////////////////////////////////////////////////////////
module testbench;
   logic                            clk, rstn, ce, parallel, chip_select_n;
   logic                            cal_cmd, diag_read, fault_now, por;
   logic                            failsafe, fault_mode, ext_run, ext_clk;
   logic                            fault_status_out_n, clock_fail, regs_reset;
   logic                            uncond_seen, regs_seen;
   logic [1:0]                      flags_read, out_on, latched, uncond_on;
   logic [11:0]                     ext_per, int_period;
   hss_pwm_pkg::chan_cfg_t [1:0]    cfg;
   hss_pwm_pkg::chan_cfg_t          eff_cfg1, exp_cfg;
   hss_pwm_pkg::chan_evt_t [1:0]    evt;
   hss_pwm_pkg::fault_flags_t [1:0] fault_evt, fault_cause, fault_flags_reg;
   int                              err_total, n_compared, hi_cnt;

   hss_ctrl #(.PER_W(12)) dut (.clk, .rstn, .ce, .cfg, .parallel, .ext_clk,
      .chip_select_n, .cal_cmd, .diag_read, .flags_read, .evt, .fault_evt,
      .fault_cause, .fault_now, .por, .failsafe, .fault_mode, .out_on,
      .fault_status_out_n, .clock_fail, .latched, .uncond_on, .regs_reset,
      .fault_flags_reg, .eff_cfg1, .int_period);
   ext_clk_src host (.clk(clk), .run(ext_run), .period(ext_per), .ext_clk(ext_clk));

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   // one-cycle pulses are easy to miss by sampling, so latch them
   always @(posedge clk) begin
      if (uncond_on[0]) uncond_seen <= 1'h1;
      if (regs_reset) regs_seen <= 1'h1;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic latch(input int ch, input logic [5:0] f);
      @(posedge clk) evt[ch].latch_evt <= 1'h1;
      evt[ch].cause <= 1'h1;
      fault_evt[ch] <= f;
      @(posedge clk) evt[ch].latch_evt <= 1'h0;
      fault_evt[ch] <= 6'h00;
      tick(3);
   endtask
   task automatic toggle_on;
      @(posedge clk) cfg[0].on <= 1'h0;
      tick(3);
      cfg[0].on <= 1'h1;
      tick(4);
   endtask
   task automatic toggle_in;
      @(posedge clk) evt[0].in_pin <= 1'h0;
      tick(3);
      evt[0].in_pin <= 1'h1;
      tick(4);
   endtask
   task automatic cal(input int n);
      @(posedge clk) cal_cmd <= 1'h1;
      @(posedge clk) cal_cmd <= 1'h0;
      chip_select_n <= 1'h0;
      tick(n);
      chip_select_n <= 1'h1;
      tick(3);
   endtask
   task automatic read0;
      @(posedge clk) flags_read <= 2'h1;
      @(posedge clk) flags_read <= 2'h0;
      tick(3);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      // tests take about 75k cycles; give up at 90k
      #4500000;
      err_total++;
      end_of_test;
   end

   initial begin
      rstn = 1'h0; ce = 1'h1; parallel = 1'h0; chip_select_n = 1'h1;
      cal_cmd = 1'h0; diag_read = 1'h0; flags_read = 2'h0; fault_now = 1'h0;
      por = 1'h0; failsafe = 1'h0; fault_mode = 1'h0; ext_run = 1'h0;
      ext_per = 12'd200; cfg = '0; evt = '0; fault_evt = '0; fault_cause = '0;
      uncond_seen = 1'h0; regs_seen = 1'h0; err_total = 0; n_compared = 0;
      tick(6);
      rstn <= 1'h1;
      tick(3);
      chk(fault_status_out_n, 1);
      chk(int_period, `INT_PER_DEF_CYC);
      fault_now <= 1'h1;
      tick(3);
      chk(fault_status_out_n, 0);
      fault_now <= 1'h0;
      cfg[0].on <= 1'h1;
      cfg[0].dir_dis <= 1'h1;
      ce <= 1'h0;
      tick(3);
      // frozen while the clock enable is low
      chk(out_on, 2'h0);
      ce <= 1'h1;
      tick(3);
      chk(out_on, 2'h1);
      // calibration at both window edges
      cal(`CSB_MIN_CYC);
      chk(int_period, `CSB_MIN_CYC);
      cal(`CSB_MIN_CYC - 1);
      chk(int_period, `CSB_MIN_CYC);
      cal(`CSB_MAX_CYC + 1);
      chk(int_period, `CSB_MIN_CYC);
      // external clock PWM, duty 3: four ticks high per 256
      cfg[0].duty <= 8'h03;
      ext_run <= 1'h1;
      tick(10);
      cfg[0].pwm_en <= 1'h1;
      tick(1000);
      hi_cnt = 0;
      repeat (256 * 200) begin
         @(negedge clk);
         hi_cnt += out_on[0];
      end
      chk(hi_cnt, 4 * 200);
      chk(clock_fail, 0);
      // clock stops: failure, then clears only after read
      ext_run <= 1'h0;
      tick(2100);
      chk({clock_fail, fault_status_out_n, out_on[0]}, 3'h5);
      ext_run <= 1'h1;
      tick(600);
      chk(clock_fail, 1);
      diag_read <= 1'h1;
      @(posedge clk) diag_read <= 1'h0;
      tick(600);
      chk({clock_fail, fault_status_out_n}, 2'h1);
      // prescaled clock, delay code 1: full on only after 32 ticks of 400 cycles
      cfg[0].pwm_en <= 1'h0;
      cfg[0].duty <= `DUTY_FULL;
      cfg[0].prescale <= 1'h1;
      cfg[0].delay <= 3'h1;
      tick(2);
      cfg[0].pwm_en <= 1'h1;
      tick(9000);
      chk(out_on[0], 0);
      tick(4000);
      chk(out_on[0], 1);
      // internal clock: no monitoring of the stopped external clock
      cfg[0].clk_int <= 1'h1;
      ext_run <= 1'h0;
      tick(2500);
      chk({clock_fail, out_on[0]}, 2'h1);
      cfg[0].pwm_en <= 1'h0;
      // delatch through the on bit, refused while cause remains
      latch(0, 6'h09);
      chk({latched, fault_status_out_n}, 3'h2);
      toggle_on;
      chk(latched, 2'h1);
      read0;
      chk(fault_flags_reg[0], 6'h01);
      evt[0].cause <= 1'h0;
      toggle_on;
      chk({latched, fault_status_out_n}, 3'h1);
      read0;
      chk(fault_flags_reg[0], 6'h00);
      // direct input delatch, blocked when direct control is disabled
      cfg[0].on <= 1'h0;
      cfg[0].dir_dis <= 1'h0;
      evt[0].in_pin <= 1'h1;
      latch(0, 6'h00);
      evt[0].cause <= 1'h0;
      toggle_in;
      chk(latched, 2'h0);
      cfg[0].dir_dis <= 1'h1;
      latch(0, 6'h00);
      evt[0].cause <= 1'h0;
      toggle_in;
      chk(latched, 2'h1);
      // retry counter reset delatches at the turn-on
      evt[0].retry_en <= 1'h1;
      evt[0].retry_reset <= 1'h1;
      @(posedge clk) evt[0].retry_reset <= 1'h0;
      tick(2);
      evt[0].retry_turn_on <= 1'h1;
      @(posedge clk) evt[0].retry_turn_on <= 1'h0;
      tick(3);
      chk(latched, 2'h0);
      // delatch sequence during retry
      evt[0].retry_busy <= 1'h1;
      cfg[0].on <= 1'h1;
      tick(3);
      toggle_on;
      chk(uncond_seen, 1);
      evt[0].retry_busy <= 1'h0;
      // power-on clears latches and flags
      latch(0, 6'h04);
      latch(1, 6'h02);
      por <= 1'h1;
      @(posedge clk) por <= 1'h0;
      tick(3);
      chk({latched, fault_flags_reg}, 14'h0000);
      // fail-safe entry from fault mode, then new faults in fail-safe
      latch(0, 6'h00);
      fault_mode <= 1'h1;
      failsafe <= 1'h1;
      tick(3);
      chk({latched, regs_seen}, 3'h1);
      latch(0, 6'h00);
      tick(3);
      chk(latched, 2'h1);
      fault_mode <= 1'h0;
      failsafe <= 1'h0;
      evt[0].cause <= 1'h0;
      toggle_on;
      // parallel mirroring of settings and flags
      parallel <= 1'h1;
      cfg[0].delay <= 3'h5;
      cfg[1].duty <= 8'h7e;
      cfg[1].diag_cfg <= 3'h4; // open-load checks left off on channel 1
      tick(3);
      exp_cfg = cfg[0];
      exp_cfg.diag_cfg = cfg[1].diag_cfg;
      chk(eff_cfg1, exp_cfg);
      fault_evt[0] <= 6'h09;
      @(posedge clk) fault_evt[0] <= 6'h00;
      tick(3);
      chk(fault_flags_reg[1], 6'h01);
      end_of_test;
   end
endmodule // testbench
